// ### design/igss_pkg.sv
// Constants, register layouts and carrier types of the interrupt group and signaling block.
package igss_pkg;
  localparam int N_SOFT   = 16;
  localparam int N_LOCAL  = 32;
  localparam int N_SHR    = 32;
  localparam int N_MSG    = 8;
  localparam int SHR_BASE = 32;
  localparam int MSG_BASE = 64;
  localparam int N_IRQ    = 72;
  localparam logic [6:0] ID_SPUR = 7'h7f;
  // Byte addresses of the word registers.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PECFG  = 8'h04;
  localparam logic [7:0] OFS_ROUTE  = 8'h08;
  localparam logic [7:0] OFS_CPUEN  = 8'h0c;
  localparam logic [7:0] OFS_BP     = 8'h10;
  localparam logic [7:0] OFS_NSACC  = 8'h14;
  localparam logic [7:0] OFS_LSET   = 8'h18;
  localparam logic [7:0] OFS_LCLR   = 8'h1c;
  localparam logic [7:0] OFS_LGRP   = 8'h20;
  localparam logic [7:0] OFS_LMOD   = 8'h24;
  localparam logic [7:0] OFS_SSET   = 8'h28;
  localparam logic [7:0] OFS_SCLR   = 8'h2c;
  localparam logic [7:0] OFS_SGRP   = 8'h30;
  localparam logic [7:0] OFS_SMOD   = 8'h34;
  localparam logic [7:0] OFS_DSET0  = 8'h38;
  localparam logic [7:0] OFS_DCLR0  = 8'h3c;
  localparam logic [7:0] OFS_ACK    = 8'h40;
  localparam logic [7:0] OFS_EOI    = 8'h44;
  localparam logic [7:0] OFS_STAT   = 8'h48;
  localparam logic [7:0] OFS_MSGEN  = 8'h4c;
  localparam logic [7:0] OFS_MSGPND = 8'h50;
  // Exception levels and soft interrupt generation register kinds.
  localparam logic [1:0] LVL_USER   = 2'h0;
  localparam logic [1:0] LVL_KERNEL = 2'h1;
  localparam logic [1:0] LVL_HYP    = 2'h2;
  localparam logic [1:0] LVL_MON    = 2'h3;
  localparam logic [1:0] SGK_G0     = 2'h0;
  localparam logic [1:0] SGK_G1     = 2'h1;
  localparam logic [1:0] SGK_ALIAS  = 2'h2;

  typedef enum logic [1:0] {GRP_G0, GRP_SG1, GRP_NSG1} igss_grp_type;
  typedef enum logic {BUS_IDLE, BUS_ANS} igss_bus_type;

  typedef struct packed {
    logic [25:0] rsvd;
    logic        affinity_on;
    logic        message_irq_on;
    logic        dist_nonsecure_g1_on;
    logic        dist_secure_g1_on;
    logic        dist_group0_on;
    logic        security_split_off;
  } igss_ctrl_type;

  typedef struct packed {
    logic [24:0] rsvd;
    logic        fast_bypass_disable;
    logic        lower_sysreg_allow;
    logic        sysreg_iface_sel;
    logic        monitor_narrow;
    logic        secure_only;
    logic        has_hyp;
    logic        has_monitor;
  } igss_pecfg_type;

  typedef struct packed {
    logic [26:0] rsvd;
    logic        normal_virt_override;
    logic        fast_virt_override;
    logic        nonsecure_select;
    logic        route_normal_to_monitor;
    logic        route_fast_to_monitor;
  } igss_route_type;

  typedef struct packed {
    logic [26:0] rsvd;
    logic        mon_g1ns_on;
    logic        mon_g1s_on;
    logic        cpu_group1_on_ns;
    logic        cpu_group1_on_s;
    logic        cpu_group0_on;
  } igss_cpuen_type;

  typedef struct packed {
    logic [19:0] rsvd;
    logic        shared_bp_nonsecure;
    logic        shared_bp_secure;
    logic        shared_binary_point;
    logic [2:0]  group1_binary_point_ns;
    logic [2:0]  group1_binary_point_s;
    logic [2:0]  group0_binary_point;
  } igss_bp_type;

  typedef struct packed {
    logic [1:0] nroute;
    logic [1:0] froute;
    logic       virt;
    logic       normal;
    logic       fast;
  } igss_lines_type;

  typedef struct packed {
    logic       req;
    logic [1:0] kind;
    logic [3:0] id;
  } igss_sgi_type;

  typedef struct packed {
    igss_bus_type   bus;
    logic [31:0]    rdata;
    igss_ctrl_type  ctrl;
    igss_pecfg_type pecfg;
    igss_route_type route;
    igss_cpuen_type cpuen;
    igss_bp_type    bp;
    logic [1:0]     nsacc;
    logic [N_IRQ-1:0] en;
    logic [MSG_BASE-1:0] grp;
    logic [MSG_BASE-1:0] modf;
    logic [N_SOFT-1:0] soft_pend;
    logic [N_MSG-1:0]  msg_pend;
    logic [N_IRQ-1:0]  act;
    igss_lines_type    lines;
    logic              sgi_done;
    logic              sgi_trap;
    logic              sgi_refused;
  } igss_state_type;

  localparam igss_state_type ST_RST = '0;
endpackage

// ### design/igss_top.sv
// Group, security and request line logic of one CPU interface with its distributor gates.
`timescale 1ns/1ps
module igss_top
  import igss_pkg::*;
#(
  parameter bit SOFT_ALWAYS_ON = 1'b0
)
(
  input  wire logic           clk_i,
  input  wire logic           rst_n_i,
  input  wire logic [7:0]     avs_address_i,
  input  wire logic           avs_read_i,
  input  wire logic           avs_write_i,
  input  wire logic [31:0]    avs_writedata_i,
  input  wire logic [3:0]     avs_byteenable_i,
  output logic [31:0]         avs_readdata_o,
  output logic                avs_waitrequest_o,
  input  wire logic           req_nonsecure_i,
  input  wire logic [1:0]     pe_level_i,
  input  wire logic [15:0]    priv_irq_i,
  input  wire logic [31:0]    shr_irq_i,
  input  wire logic [N_MSG-1:0] msg_set_i,
  input  wire igss_sgi_type   sgi_i,
  output igss_lines_type      lines_o,
  output logic                sgi_done_o,
  output logic                sgi_trap_o,
  output logic                sgi_refused_o
);

  igss_state_type s_q;
  igss_state_type s_d;
  logic           mon;
  logic           ds;
  logic           e_ns;
  logic           e_rf;
  logic           e_rn;
  logic           e_g0;
  logic           e_g1s;
  logic           e_g1ns;
  logic           cur_sec;
  logic           virt;
  logic           hp_valid;
  logic           dok;
  logic           cok;
  logic           allow;
  logic [6:0]     hp_id;
  logic [6:0]     id;
  logic [31:0]    m;
  logic [31:0]    w;
  logic [31:0]    rd;
  logic [2:0]     bp_s;
  logic [2:0]     bp_ns;
  logic [N_IRQ-1:0] pend;
  logic [N_IRQ-1:0] elig;
  logic [N_IRQ-1:0] nsm;
  igss_grp_type   cls_raw [N_IRQ];
  igss_grp_type   cls_cpu [N_IRQ];
  igss_grp_type   hp_cls;
  igss_grp_type   hp_raw;
  igss_grp_type   tgt;

  // Byte-lane merge of a plain register write.
  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] d,
                                      input logic [31:0] k);
    mrg = (o & ~k) | (d & k);
  endfunction

  // Next-state logic: effective configuration, selection, lines, soft generation and bus.
  always_comb
  begin
    s_d = s_q;
    mon = s_q.pecfg.has_monitor;
    ds = s_q.ctrl.security_split_off;
    e_ns = s_q.route.nonsecure_select;
    e_rf = s_q.route.route_fast_to_monitor;
    e_rn = s_q.route.route_normal_to_monitor;
    e_g0 = s_q.cpuen.cpu_group0_on;
    e_g1s = s_q.cpuen.cpu_group1_on_s & s_q.cpuen.mon_g1s_on;
    e_g1ns = s_q.cpuen.cpu_group1_on_ns & s_q.cpuen.mon_g1ns_on;
    if (!mon && ds)
    begin
      e_ns = 1'b1;
      e_rf = 1'b0;
      e_rn = 1'b0;
    end
    else if (!mon && !s_q.pecfg.secure_only)
    begin
      e_ns = 1'b1;
      e_rf = 1'b1;
      e_rn = 1'b0;
      e_g0 = 1'b0;
      e_g1s = 1'b0;
    end
    else if (!mon)
    begin
      e_ns = 1'b0;
      e_rf = 1'b0;
      e_rn = 1'b0;
      e_g1ns = 1'b0;
    end
    cur_sec = (pe_level_i == LVL_MON) || !e_ns;
    virt = e_ns && (s_q.route.fast_virt_override || s_q.route.normal_virt_override);
    hp_valid = 1'b0;
    hp_id = ID_SPUR;
    hp_cls = GRP_G0;
    hp_raw = GRP_G0;
    dok = 1'b0;
    cok = 1'b0;
    // Per-interrupt group, pending source, gating and lowest-index selection.
    for (int i = 0; i < N_IRQ; i++)
    begin
      if (i >= MSG_BASE || s_q.grp[i % MSG_BASE])
        cls_raw[i] = GRP_NSG1;
      else if (s_q.modf[i % MSG_BASE] && !ds)
        cls_raw[i] = GRP_SG1;
      else
        cls_raw[i] = GRP_G0;
      if (cls_raw[i] == GRP_SG1 && (!mon || !s_q.pecfg.sysreg_iface_sel))
        cls_cpu[i] = GRP_G0;
      else
        cls_cpu[i] = cls_raw[i];
      case (cls_raw[i])
        GRP_G0:   dok = s_q.ctrl.dist_group0_on;
        GRP_SG1:  dok = s_q.ctrl.dist_secure_g1_on;
        default:  dok = s_q.ctrl.dist_nonsecure_g1_on;
      endcase
      case (cls_cpu[i])
        GRP_G0:   cok = e_g0;
        GRP_SG1:  cok = e_g1s;
        default:  cok = e_g1ns;
      endcase
      if (i < N_SOFT)
        pend[i] = s_q.soft_pend[i];
      else if (i < N_LOCAL)
        pend[i] = priv_irq_i[i - N_SOFT];
      else if (i < MSG_BASE)
        pend[i] = shr_irq_i[i - SHR_BASE];
      else
        pend[i] = s_q.msg_pend[i - MSG_BASE];
      elig[i] = pend[i] && s_q.en[i] && !s_q.act[i] && dok && cok;
      nsm[i] = ds || !req_nonsecure_i || cls_raw[i] == GRP_NSG1;
      if (elig[i] && !hp_valid)
      begin
        hp_valid = 1'b1;
        hp_id = 7'(i);
        hp_cls = cls_cpu[i];
        hp_raw = cls_raw[i];
      end
    end
    // Request line choice for the selected interrupt, registered every cycle.
    s_d.lines.fast = 1'b0;
    s_d.lines.normal = 1'b0;
    if (hp_valid)
    begin
      if (hp_cls == GRP_G0)
        s_d.lines.fast = 1'b1;
      else if (ds || !mon)
        s_d.lines.normal = 1'b1;
      else if (((hp_cls == GRP_SG1) != cur_sec) ||
               (pe_level_i == LVL_MON && !s_q.pecfg.monitor_narrow))
        s_d.lines.fast = 1'b1;
      else
        s_d.lines.normal = 1'b1;
    end
    s_d.lines.virt = virt && (pe_level_i == LVL_KERNEL);
    s_d.lines.froute = e_rf ? LVL_MON :
                       (e_ns && s_q.route.fast_virt_override) ? LVL_HYP : LVL_KERNEL;
    s_d.lines.nroute = e_rn ? LVL_MON :
                       (e_ns && s_q.route.normal_virt_override) ? LVL_HYP : LVL_KERNEL;
    // Effective binary points per security state.
    bp_s = (s_q.bp.shared_bp_secure || (s_q.bp.shared_binary_point && cur_sec)) ?
           s_q.bp.group0_binary_point : s_q.bp.group1_binary_point_s;
    bp_ns = (s_q.bp.shared_bp_nonsecure || (s_q.bp.shared_binary_point && !cur_sec)) ?
            s_q.bp.group0_binary_point : s_q.bp.group1_binary_point_ns;
    // Read multiplexer, captured when the access is accepted.
    rd = '0;
    case (avs_address_i)
      OFS_CTRL:   rd = s_q.ctrl;
      OFS_PECFG:  rd = s_q.pecfg;
      OFS_ROUTE:  rd = s_q.route;
      OFS_CPUEN:  rd = s_q.cpuen;
      OFS_BP:     rd = s_q.bp;
      OFS_NSACC:  rd = {30'h00000000, s_q.nsacc};
      OFS_LSET, OFS_LCLR, OFS_DSET0, OFS_DCLR0:
        rd = s_q.en[N_LOCAL-1:0] & nsm[N_LOCAL-1:0];
      OFS_LGRP:   rd = s_q.grp[N_LOCAL-1:0] & nsm[N_LOCAL-1:0];
      OFS_LMOD:   rd = s_q.modf[N_LOCAL-1:0] & nsm[N_LOCAL-1:0];
      OFS_SSET, OFS_SCLR:
        rd = s_q.en[SHR_BASE +: N_SHR] & nsm[SHR_BASE +: N_SHR];
      OFS_SGRP:   rd = s_q.grp[SHR_BASE +: N_SHR] & nsm[SHR_BASE +: N_SHR];
      OFS_SMOD:   rd = s_q.modf[SHR_BASE +: N_SHR] & nsm[SHR_BASE +: N_SHR];
      OFS_ACK:
        rd = {25'h0000000, (hp_valid && (ds || !req_nonsecure_i || hp_raw == GRP_NSG1)) ?
              hp_id : ID_SPUR};
      OFS_STAT:   rd = {11'h000, bp_ns, bp_s, s_q.lines, hp_valid, hp_id};
      OFS_MSGEN:  rd = {24'h000000, s_q.en[MSG_BASE +: N_MSG]};
      OFS_MSGPND: rd = {24'h000000, s_q.msg_pend};
      default:    rd = '0;
    endcase
    m = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
         {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    w = avs_writedata_i & m;
    id = avs_writedata_i[6:0];
    // Bus sequencing: accept, then answer one cycle later with all write effects.
    case (s_q.bus)
      BUS_IDLE:
      begin
        if (avs_read_i || avs_write_i)
        begin
          s_d.bus = BUS_ANS;
          s_d.rdata = avs_read_i ? rd : '0;
        end
      end
      BUS_ANS:
      begin
        s_d.bus = BUS_IDLE;
        if (avs_read_i && avs_address_i == OFS_ACK && s_q.rdata[6:0] != ID_SPUR)
        begin
          s_d.act[s_q.rdata[6:0]] = 1'b1;
          if (s_q.rdata[6:0] < 7'(N_SOFT))
            s_d.soft_pend[s_q.rdata[3:0]] = 1'b0;
          if (s_q.rdata[6:0] >= 7'(MSG_BASE))
            s_d.msg_pend[s_q.rdata[2:0]] = 1'b0;
        end
        if (avs_write_i)
        begin
          case (avs_address_i)
            OFS_CTRL:
            begin
              s_d.ctrl = igss_ctrl_type'(mrg(s_q.ctrl, avs_writedata_i, m));
              s_d.ctrl.rsvd = '0;
            end
            OFS_PECFG:
            begin
              s_d.pecfg = igss_pecfg_type'(mrg(s_q.pecfg, avs_writedata_i, m));
              s_d.pecfg.rsvd = '0;
            end
            OFS_ROUTE:
            begin
              s_d.route = igss_route_type'(mrg(s_q.route, avs_writedata_i, m));
              s_d.route.rsvd = '0;
            end
            OFS_CPUEN:
            begin
              s_d.cpuen = igss_cpuen_type'(mrg(s_q.cpuen, avs_writedata_i, m));
              s_d.cpuen.rsvd = '0;
            end
            OFS_BP:
            begin
              s_d.bp = igss_bp_type'(mrg(s_q.bp, avs_writedata_i, m));
              s_d.bp.rsvd = '0;
            end
            OFS_NSACC:  s_d.nsacc = 2'(mrg({30'h00000000, s_q.nsacc}, avs_writedata_i, m));
            OFS_LSET:
              if (s_q.ctrl.affinity_on)
                s_d.en[N_LOCAL-1:0] = s_q.en[N_LOCAL-1:0] | (w & nsm[N_LOCAL-1:0]);
            OFS_LCLR:
              if (s_q.ctrl.affinity_on)
                s_d.en[N_LOCAL-1:0] = s_q.en[N_LOCAL-1:0] & ~(w & nsm[N_LOCAL-1:0]);
            OFS_DSET0:
              if (!s_q.ctrl.affinity_on)
                s_d.en[N_LOCAL-1:0] = s_q.en[N_LOCAL-1:0] | (w & nsm[N_LOCAL-1:0]);
            OFS_DCLR0:
              if (!s_q.ctrl.affinity_on)
                s_d.en[N_LOCAL-1:0] = s_q.en[N_LOCAL-1:0] & ~(w & nsm[N_LOCAL-1:0]);
            OFS_SSET:
              s_d.en[SHR_BASE +: N_SHR] = s_q.en[SHR_BASE +: N_SHR] |
                                          (w & nsm[SHR_BASE +: N_SHR]);
            OFS_SCLR:
              s_d.en[SHR_BASE +: N_SHR] = s_q.en[SHR_BASE +: N_SHR] &
                                          ~(w & nsm[SHR_BASE +: N_SHR]);
            OFS_LGRP:   s_d.grp[N_LOCAL-1:0] = mrg(s_q.grp[N_LOCAL-1:0], avs_writedata_i,
                                                   m & nsm[N_LOCAL-1:0]);
            OFS_LMOD:   s_d.modf[N_LOCAL-1:0] = mrg(s_q.modf[N_LOCAL-1:0], avs_writedata_i,
                                                    m & nsm[N_LOCAL-1:0]);
            OFS_SGRP:   s_d.grp[SHR_BASE +: N_SHR] = mrg(s_q.grp[SHR_BASE +: N_SHR],
                                      avs_writedata_i, m & nsm[SHR_BASE +: N_SHR]);
            OFS_SMOD:   s_d.modf[SHR_BASE +: N_SHR] = mrg(s_q.modf[SHR_BASE +: N_SHR],
                                      avs_writedata_i, m & nsm[SHR_BASE +: N_SHR]);
            OFS_EOI:
              if (id < 7'(N_IRQ) && (ds || !req_nonsecure_i || cls_raw[id] == GRP_NSG1))
                s_d.act[id] = 1'b0;
            OFS_MSGEN:  s_d.en[MSG_BASE +: N_MSG] = 8'(mrg({24'h000000, s_q.en[MSG_BASE +: N_MSG]},
                                                       avs_writedata_i, m));
            OFS_MSGPND: s_d.msg_pend = s_q.msg_pend & ~w[N_MSG-1:0];
            default:    s_d.bus = BUS_IDLE;
          endcase
        end
      end
      default:    s_d.bus = BUS_IDLE;
    endcase
    if (SOFT_ALWAYS_ON)
      s_d.en[N_SOFT-1:0] = '1;
    // Soft interrupt generation; a set after a clear in the same cycle wins.
    s_d.sgi_done = 1'b0;
    s_d.sgi_trap = 1'b0;
    s_d.sgi_refused = 1'b0;
    tgt = GRP_G0;
    allow = 1'b0;
    if (sgi_i.req)
    begin
      if (ds)
        tgt = (sgi_i.kind == SGK_G0) ? GRP_G0 : GRP_NSG1;
      else if (sgi_i.kind == SGK_G1)
        tgt = cur_sec ? GRP_SG1 : GRP_NSG1;
      else if (sgi_i.kind == SGK_ALIAS)
        tgt = cur_sec ? GRP_NSG1 : GRP_SG1;
      allow = ds || cur_sec || sgi_i.kind == SGK_G1 ||
              (sgi_i.kind == SGK_G0 && s_q.nsacc[0]) ||
              (sgi_i.kind == SGK_ALIAS && s_q.nsacc[1]);
      if (pe_level_i == LVL_KERNEL && virt)
        s_d.sgi_trap = 1'b1;
      else if (allow && cls_raw[sgi_i.id] == tgt)
      begin
        s_d.soft_pend[sgi_i.id] = 1'b1;
        s_d.sgi_done = 1'b1;
      end
      else
        s_d.sgi_refused = 1'b1;
    end
    if (s_q.ctrl.message_irq_on)
      s_d.msg_pend = s_d.msg_pend | msg_set_i;
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      s_q <= ST_RST;
    else
      s_q <= s_d;
  end

  // Bus handshake and registered outputs.
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && s_q.bus != BUS_ANS;
  assign avs_readdata_o = s_q.rdata;
  assign lines_o = s_q.lines;
  assign sgi_done_o = s_q.sgi_done;
  assign sgi_trap_o = s_q.sgi_trap;
  assign sgi_refused_o = s_q.sgi_refused;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_g0_fast;
    hp_valid && hp_cls == GRP_G0 |=> lines_o.fast && !lines_o.normal;
  endproperty
  a_g0_fast: assert property (p_g0_fast) else $error("group 0 not on fast line");

  property p_single;
    hp_valid && hp_cls != GRP_G0 && (ds || !mon) |=> lines_o.normal && !lines_o.fast;
  endproperty
  a_single: assert property (p_single) else $error("single state group 1 not normal");

  property p_mon_wide;
    hp_valid && hp_cls != GRP_G0 && !ds && mon && pe_level_i == LVL_MON &&
    !s_q.pecfg.monitor_narrow |=> lines_o.fast;
  endproperty
  a_mon_wide: assert property (p_mon_wide) else $error("monitor group 1 not fast");

  property p_narrow;
    hp_valid && hp_cls == GRP_SG1 && !ds && mon && pe_level_i == LVL_MON &&
    s_q.pecfg.monitor_narrow |=> lines_o.normal && !lines_o.fast;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow monitor secure g1 wrong");

  property p_trap;
    sgi_i.req && pe_level_i == LVL_KERNEL && virt |=> sgi_trap_o && !sgi_done_o;
  endproperty
  a_trap: assert property (p_trap) else $error("virtual soft generation did not trap");

  property p_msg_off;
    !s_q.ctrl.message_irq_on && s_q.msg_pend == '0 |=> s_q.msg_pend == '0;
  endproperty
  a_msg_off: assert property (p_msg_off) else $error("message pending while off");

  property p_dist_off;
    (!s_q.ctrl.dist_group0_on && !s_q.ctrl.dist_secure_g1_on &&
     !s_q.ctrl.dist_nonsecure_g1_on) [*2] |-> !lines_o.fast && !lines_o.normal;
  endproperty
  a_dist_off: assert property (p_dist_off) else $error("line raised with groups off");

  property p_ns_only;
    !mon && !ds && !s_q.pecfg.secure_only && hp_valid |-> hp_cls == GRP_NSG1;
  endproperty
  a_ns_only: assert property (p_ns_only) else $error("nonsecure element got secure");

  property p_s_only;
    !mon && !ds && s_q.pecfg.secure_only && hp_valid |-> hp_cls != GRP_NSG1;
  endproperty
  a_s_only: assert property (p_s_only) else $error("secure element got nonsecure");
endmodule

// ### verification/igss_pe_model.sv
// Processing element model that changes exception level and issues soft generation requests.
`timescale 1ns/1ps
module igss_pe_model
  import igss_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [2:0] resp_i,
  output logic [1:0]      pe_level_o,
  output igss_sgi_type    sgi_o
);
  // The element starts at kernel level with no request pending.
  initial
  begin
    pe_level_o = LVL_KERNEL;
    sgi_o      = '0;
  end
  // Takes or returns from an exception just after an edge, as a real core would.
  task automatic go(input logic [1:0] lvl);
    @(posedge clk_i);
    pe_level_o <= lvl;
  endtask
  // Sends a one-cycle request and samples the done, trap and refused pulses a cycle later.
  task automatic gen(input logic [1:0] kind, output logic [2:0] r);
    @(posedge clk_i);
    sgi_o <= '{req: 1'b1, kind: kind, id: 4'h0};
    @(posedge clk_i);
    sgi_o <= '0;
    @(posedge clk_i);
    r = resp_i;
  endtask
endmodule

// ### verification/irq_group_security_signaling_bench.sv
// Self-checking bench of the group, security and request line logic.
`timescale 1ns/1ps
module irq_group_security_signaling_bench
  import igss_pkg::*;
;
  logic           clk_i = 1'b0;
  logic           rst_n_i, rd, wr, ns, wq;
  logic [7:0]     addr, msg;
  logic [31:0]    wd, rdat, got, shr;
  logic [15:0]    priv;
  logic [1:0]     lvl;
  logic [2:0]     resp, r;
  igss_sgi_type   soft_interrupt;
  igss_lines_type lines;
  int             n_errors = 0;
  int             comparisons = 0;
  int             cycles = 0;
  igss_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wq), .req_nonsecure_i(ns), .pe_level_i(lvl), .priv_irq_i(priv),
    .shr_irq_i(shr), .msg_set_i(msg), .sgi_i(soft_interrupt), .lines_o(lines), .sgi_done_o(resp[2]),
    .sgi_trap_o(resp[1]), .sgi_refused_o(resp[0]));
  igss_pe_model u_pe (.clk_i(clk_i), .resp_i(resp), .pe_level_o(lvl), .sgi_o(soft_interrupt));
  always #20 clk_i = ~clk_i;
  // A hang is cut short well past the length of all tests.
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (e !== g)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One Avalon cycle held until waitrequest is seen low; read data is taken at that edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic n);
    @(posedge clk_i);
    wr <= w;
    rd <= ~w;
    addr <= a;
    wd <= d;
    ns <= n;
    @(posedge clk_i);
    while (wq !== 1'b0)
      @(posedge clk_i);
    got = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic w_(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b0);
  endtask
  // Lines are registered, so a change shows within a few edges.
  task automatic ln(input string nm, input logic [1:0] e);
    repeat (3) @(posedge clk_i);
    chk(nm, {30'h0, e}, {30'h0, lines.normal, lines.fast});
  endtask
  task automatic pulse_msg();
    @(posedge clk_i);
    msg <= 8'h01;
    @(posedge clk_i);
    msg <= 8'h00;
    bus(1'b0, OFS_MSGPND, 32'h0, 1'b0);
  endtask
  // The control register reset value and the unmapped hole read back as zero.
  task automatic test_reset();
    bus(1'b0, OFS_CTRL, 32'h0, 1'b0);
    chk("ctrl reset", 32'h0, got);
    bus(1'b0, 8'hfc, 32'h0, 1'b0);
    chk("unmapped", 32'h0, got);
    $display("reset test done");
  endtask
  // Single security state: group 0 fast, group 1 normal at every level.
  task automatic test_single();
    w_(OFS_CTRL, 32'h2f);
    w_(OFS_CPUEN, 32'h1f);
    w_(OFS_LGRP, 32'h0002_0000);
    w_(OFS_LSET, 32'h0003_0000);
    u_pe.gen(SGK_G0, r);
    chk("gen single", 32'h4, {29'h0, r});
    priv <= 16'h0001;
    ln("g0 single", 2'b01);
    priv <= 16'h0002;
    for (int l = 0; l < 4; l++)
    begin
      u_pe.go(l[1:0]);
      ln("g1 single", 2'b10);
    end
    priv <= 16'h0000;
    $display("single state test done");
  endtask
  // Two security states with a monitor level.
  task automatic test_two_state();
    w_(OFS_CTRL, 32'h2e);
    w_(OFS_PECFG, 32'h13);
    w_(OFS_ROUTE, 32'h04);
    w_(OFS_SGRP, 32'h2);
    w_(OFS_SMOD, 32'h1);
    w_(OFS_SSET, 32'h3);
    u_pe.go(LVL_KERNEL);
    shr <= 32'h1;
    ln("sg1 at ns", 2'b01);
    u_pe.go(LVL_MON);
    ln("sg1 at mon", 2'b01);
    shr <= 32'h2;
    ln("nsg1 at mon", 2'b01);
    u_pe.go(LVL_KERNEL);
    ln("nsg1 at ns", 2'b10);
    w_(OFS_ROUTE, 32'h0);
    ln("nsg1 at s", 2'b01);
    shr <= 32'h1;
    ln("sg1 at s", 2'b10);
    w_(OFS_PECFG, 32'h03);
    ln("sg1 as g0", 2'b01);
    w_(OFS_PECFG, 32'h1b);
    u_pe.go(LVL_MON);
    ln("narrow sg1", 2'b10);
    shr <= 32'h2;
    ln("narrow nsg1", 2'b01);
    bus(1'b0, OFS_SMOD, 32'h0, 1'b1);
    chk("ns view", 32'h0, got);
    bus(1'b0, OFS_SMOD, 32'h0, 1'b0);
    chk("s view", 32'h1, got);
    $display("two state test done");
  endtask
  // Individual enables, acknowledge security, group and message enables.
  task automatic test_enables();
    w_(OFS_SCLR, 32'h0);
    bus(1'b0, OFS_SSET, 32'h0, 1'b0);
    chk("clear zero", 32'h3, got);
    w_(OFS_SCLR, 32'h2);
    bus(1'b0, OFS_SSET, 32'h0, 1'b0);
    chk("clear one", 32'h1, got);
    ln("disabled", 2'b00);
    shr <= 32'h1;
    ln("sg1 on", 2'b10);
    bus(1'b0, OFS_ACK, 32'h0, 1'b1);
    chk("ack ns", 32'h7f, got);
    bus(1'b0, OFS_ACK, 32'h0, 1'b0);
    chk("ack s", 32'h20, got);
    ln("acked", 2'b00);
    w_(OFS_EOI, 32'h20);
    ln("eoi", 2'b10);
    w_(OFS_CTRL, 32'h2a);
    ln("sg1 group off", 2'b00);
    shr <= 32'h0;
    pulse_msg();
    chk("msg off", 32'h0, got);
    w_(OFS_CTRL, 32'h3a);
    pulse_msg();
    chk("msg on", 32'h1, got);
    $display("enable test done");
  endtask
  // Soft generation from the nonsecure kernel level, then binary points and routes.
  task automatic test_soft_gen();
    w_(OFS_ROUTE, 32'h04);
    u_pe.go(LVL_KERNEL);
    u_pe.gen(SGK_G0, r);
    chk("gen refused", 32'h1, {29'h0, r});
    w_(OFS_NSACC, 32'h1);
    u_pe.gen(SGK_G0, r);
    chk("gen allowed", 32'h4, {29'h0, r});
    u_pe.gen(SGK_G1, r);
    chk("gen wrong group", 32'h1, {29'h0, r});
    w_(OFS_ROUTE, 32'h0c);
    u_pe.gen(SGK_G0, r);
    chk("gen trap", 32'h2, {29'h0, r});
    chk("virtual", 32'h1, {31'h0, lines.virt});
    w_(OFS_BP, 32'h995);
    bus(1'b0, OFS_STAT, 32'h0, 1'b0);
    chk("stat bp route", 32'h15347f, got);
    $display("soft generation test done");
  endtask
  // Reset for three edges, then every scenario in turn and the verdict.
  initial
  begin
    {rst_n_i, rd, wr, ns, addr, wd, msg, shr, priv} = '0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    test_reset();
    test_single();
    test_two_state();
    test_enables();
    test_soft_gen();
    tally_and_finish();
  end
endmodule
